// ### rtl/sst_pkg.sv
//Contract
//- The light-sleep entry delay is (code+1) times 128 ms, 128 ms to 2048 ms of no motion.
//- After reset the light-sleep entry code is 0001, a 256 ms delay.
//- The deep-sleep entry delay is (code+1) times 20480 ms, 20480 ms to 327680 ms.
//- After reset the deep-sleep entry code is 0010, a 61440 ms delay.
//- In deep sleep the sensor samples every (code+1) times 32 ms, 32 ms to 512 ms.
//- The deep-sleep poll code resets to 1001 (320 ms) and the low nibble is always 0010.
//- The entry-delay register holds the light code in bits 7:4 and the deep code in bits 3:0.
//- The sleep sub-state flag means something only in state 100; 0 is light, 1 is deep sleep.
`default_nettype none
package sst_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int LIGHT_STEP_MS = 128;
  localparam int DEEP_STEP_MS = 20480;
  localparam int POLL_STEP_MS = 32;
  localparam int MS_W = 19;
  localparam int POLL_W = 10;

  // ==========================================================
  // Register map (index, byte address is four times the index)
  localparam logic [7:0] ENTRY_IDX = 8'h0b;
  localparam logic [7:0] POLL_IDX = 8'h0c;
  localparam logic [7:0] STATUS_IDX = 8'h10;
  localparam logic [7:0] ENTRY_ADDR = 8'(ENTRY_IDX * 4);
  localparam logic [7:0] POLL_ADDR = 8'(POLL_IDX * 4);
  localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);

  // ==========================================================
  // Fields and reset values
  localparam int LIGHT_LSB = 4;
  localparam int DEEP_LSB = 0;
  localparam int POLL_LSB = 4;
  localparam int FLAG_BIT = 3;
  localparam logic [7:0] ENTRY_RST = 8'h12;
  localparam logic [3:0] POLL_CODE_RST = 4'h9;
  localparam logic [3:0] POLL_LOW_FIXED = 4'h2;
  localparam logic [2:0] OPS_NORMAL = 3'h0;
  localparam logic [2:0] OPS_SLEEP = 3'h4;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_LIGHT,
    ST_DEEP
  } sst_state_t;

endpackage
`default_nettype wire

// ### rtl/sst_tick.sv
`timescale 1ns/1ps
`default_nettype none
module sst_tick #(
  parameter int CYC = 25000 // Clock cycles per tick
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  output logic tick_q // One-cycle pulse every CYC cycles
);

  logic [31:0] cnt_q;

  // Free running: a delay may start anywhere inside a tick, so it can be up to one ms short
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(CYC - 1)) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### rtl/sst_timer.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sst_timer #(
  parameter int CYC_PER_MS = sst_pkg::CYC_PER_MS // Cycles per millisecond
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] addr, // Register byte address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata_q, // Read data, cycle after rd
  input wire logic motion, // Motion detected, level
  output logic [2:0] operating_state_field_q, // Operating state field
  output logic sleep_flag_q, // 0 light sleep, 1 deep sleep
  output logic poll_pulse_q // Deep-sleep sample strobe
);

  // ==========================================================
  // Registers
  logic [3:0] light_sleep_entry_code_q;
  logic [3:0] deep_sleep_entry_code_q;
  logic [3:0] deep_sleep_poll_code_q;
  logic [7:0] sleep2_poll_period;
  logic [7:0] sleep_entry_delays;

  always_ff @(posedge clk) begin
    if (rst) begin
      light_sleep_entry_code_q <= sst_pkg::ENTRY_RST[7:4];
      deep_sleep_entry_code_q <= sst_pkg::ENTRY_RST[3:0];
    end else if (wr && addr == sst_pkg::ENTRY_ADDR) begin
      light_sleep_entry_code_q <= wdata[sst_pkg::LIGHT_LSB +: 4];
      deep_sleep_entry_code_q <= wdata[sst_pkg::DEEP_LSB +: 4];
    end
  end

  // Low nibble is fixed in hardware, so a stray write cannot disturb it
  always_ff @(posedge clk) begin
    if (rst) begin
      deep_sleep_poll_code_q <= sst_pkg::POLL_CODE_RST;
    end else if (wr && addr == sst_pkg::POLL_ADDR) begin
      deep_sleep_poll_code_q <= wdata[sst_pkg::POLL_LSB +: 4];
    end
  end

  assign sleep_entry_delays = {light_sleep_entry_code_q, deep_sleep_entry_code_q};
  assign sleep2_poll_period = {deep_sleep_poll_code_q, sst_pkg::POLL_LOW_FIXED};

  // ==========================================================
  // Read port
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      if (addr == sst_pkg::ENTRY_ADDR) begin
        rdata_q <= sleep_entry_delays;
      end else if (addr == sst_pkg::POLL_ADDR) begin
        rdata_q <= sleep2_poll_period;
      end else if (addr == sst_pkg::STATUS_ADDR) begin
        rdata_q <= {4'h0, sleep_flag_q, operating_state_field_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================
  // Millisecond base
  logic tick;

  sst_tick #(
    .CYC(CYC_PER_MS)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick_q(tick)
  );

  // ==========================================================
  // Delay targets in ms
  localparam int MS_W = sst_pkg::MS_W;
  localparam int POLL_W = sst_pkg::POLL_W;
  logic [MS_W-1:0] light_target;
  logic [MS_W-1:0] deep_target;
  logic [POLL_W-1:0] poll_target;

  assign light_target = MS_W'({1'b0, light_sleep_entry_code_q} + 5'h1)
    * MS_W'(sst_pkg::LIGHT_STEP_MS);
  assign deep_target = MS_W'({1'b0, deep_sleep_entry_code_q} + 5'h1)
    * MS_W'(sst_pkg::DEEP_STEP_MS);
  assign poll_target = POLL_W'({1'b0, deep_sleep_poll_code_q} + 5'h1)
    * POLL_W'(sst_pkg::POLL_STEP_MS);

  // ==========================================================
  // Sleep state machine
  sst_pkg::sst_state_t state_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic light_due;
  logic deep_due;

  // >= so that shrinking a code mid-count still ends the wait at the next tick
  assign light_due = tick && (ms_cnt_q >= light_target - MS_W'(1));
  assign deep_due = tick && (ms_cnt_q >= deep_target - MS_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sst_pkg::ST_NORMAL;
      ms_cnt_q <= '0;
    end else if (motion) begin
      state_q <= sst_pkg::ST_NORMAL;
      ms_cnt_q <= '0;
    end else begin
      case (state_q)
        sst_pkg::ST_NORMAL: begin
          if (light_due) begin
            state_q <= sst_pkg::ST_LIGHT;
            ms_cnt_q <= '0;
          end else if (tick) begin
            ms_cnt_q <= ms_cnt_q + MS_W'(1);
          end
        end
        sst_pkg::ST_LIGHT: begin
          // Deep delay is timed from entry into light sleep
          if (deep_due) begin
            state_q <= sst_pkg::ST_DEEP;
            ms_cnt_q <= '0;
          end else if (tick) begin
            ms_cnt_q <= ms_cnt_q + MS_W'(1);
          end
        end
        sst_pkg::ST_DEEP: begin
          ms_cnt_q <= '0;
        end
        default: begin
          state_q <= sst_pkg::ST_NORMAL;
          ms_cnt_q <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      operating_state_field_q <= sst_pkg::OPS_NORMAL;
      sleep_flag_q <= 1'b0;
    end else begin
      operating_state_field_q <= (state_q == sst_pkg::ST_NORMAL) ?
        sst_pkg::OPS_NORMAL : sst_pkg::OPS_SLEEP;
      sleep_flag_q <= (state_q == sst_pkg::ST_DEEP);
    end
  end

  // ==========================================================
  // Deep-sleep polling
  logic [POLL_W-1:0] poll_cnt_q;
  logic poll_due;

  assign poll_due = tick && (poll_cnt_q >= poll_target - POLL_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      poll_cnt_q <= '0;
      poll_pulse_q <= 1'b0;
    end else if (state_q != sst_pkg::ST_DEEP || motion) begin
      poll_cnt_q <= '0;
      poll_pulse_q <= 1'b0;
    end else if (poll_due) begin
      poll_cnt_q <= '0;
      poll_pulse_q <= 1'b1;
    end else begin
      poll_cnt_q <= tick ? poll_cnt_q + POLL_W'(1) : poll_cnt_q;
      poll_pulse_q <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_codes: assert property (
    $past(rst) |-> sleep_entry_delays == sst_pkg::ENTRY_RST
      && deep_sleep_poll_code_q == sst_pkg::POLL_CODE_RST)
    else $error("entry or poll code not at reset value");

  a_entry_fields: assert property (
    wr && addr == sst_pkg::ENTRY_ADDR |=> light_sleep_entry_code_q == $past(wdata[7:4])
      && deep_sleep_entry_code_q == $past(wdata[3:0]))
    else $error("entry delay fields not written as expected");

  a_motion_wakes: assert property (
    motion |=> state_q == sst_pkg::ST_NORMAL ##1 operating_state_field_q == sst_pkg::OPS_NORMAL)
    else $error("motion did not return to normal state");

  a_light_entry: assert property (
    state_q == sst_pkg::ST_NORMAL ##1 state_q == sst_pkg::ST_LIGHT
      |-> $past(ms_cnt_q) >= $past(light_target) - MS_W'(1) && $past(tick))
    else $error("light sleep entered before its delay");

  a_deep_entry: assert property (
    state_q == sst_pkg::ST_LIGHT ##1 state_q == sst_pkg::ST_DEEP
      |-> $past(ms_cnt_q) >= $past(deep_target) - MS_W'(1) && $past(tick))
    else $error("deep sleep entered before its delay");

  a_sleep_flag: assert property (
    sleep_flag_q |-> operating_state_field_q == sst_pkg::OPS_SLEEP)
    else $error("sleep flag set outside sleep state");

  a_poll_strobe: assert property (
    tick && !motion && state_q == sst_pkg::ST_DEEP && poll_cnt_q == poll_target - POLL_W'(1)
      |=> poll_pulse_q ##1 !poll_pulse_q)
    else $error("poll strobe missing or too long");

  a_poll_low_nibble: assert property (
    rd && addr == sst_pkg::POLL_ADDR |=> rdata_q[3:0] == sst_pkg::POLL_LOW_FIXED)
    else $error("poll register low nibble not fixed");

  a_deep_holds: assert property (
    state_q == sst_pkg::ST_DEEP && !motion |=> state_q == sst_pkg::ST_DEEP)
    else $error("deep sleep left without motion");

  a_poll_in_deep: assert property (
    poll_pulse_q |-> sleep_flag_q && operating_state_field_q == sst_pkg::OPS_SLEEP)
    else $error("poll strobe outside deep sleep");

endmodule
`default_nettype wire

// ### verification/sst_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sst_timer_bench;
  // ==========================================================
  // Stimulus and design
  localparam int CPM = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic motion = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata_q;
  logic [7:0] v;
  logic [2:0] operating_state_field_q;
  logic sleep_flag_q;
  logic poll_pulse_q;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  logic [7:0] ra [6] = '{8'h2c, 8'h2c, 8'h30, 8'h30, 8'h40, 8'h44};
  logic [7:0] rw [6] = '{8'h35, 8'hf0, 8'ha2, 8'h02, 8'hff, 8'h77};
  logic [7:0] re [6] = '{8'h35, 8'hf0, 8'ha2, 8'h02, 8'h00, 8'h00};
  logic [3:0] lc [2] = '{4'h0, 4'hf};

  always #20 clk = ~clk;

  sst_timer #(.CYC_PER_MS(CPM)) i_dut (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata_q(rdata_q),
    .motion(motion),
    .operating_state_field_q(operating_state_field_q),
    .sleep_flag_q(sleep_flag_q),
    .poll_pulse_q(poll_pulse_q)
  );

  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  // Kind 0 asleep, 1 deep, 2 poll pulse, 3 awake; bounded so a stuck state cannot hang
  task automatic wait_for(input int kind, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while (cnt < 50000 && !(kind == 0 ? operating_state_field_q === 3'h4 :
      kind == 1 ? sleep_flag_q === 1'b1 :
      kind == 2 ? poll_pulse_q === 1'b1 : operating_state_field_q === 3'h0));
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(sst_pkg::ENTRY_ADDR, v);
    chk8("entry reset", 8'h12, v);
    rreg(sst_pkg::POLL_ADDR, v);
    chk8("poll reset", 8'h92, v);
    rreg(sst_pkg::STATUS_ADDR, v);
    chk8("status reset", 8'h00, v);
    for (int i = 0; i < 6; i++) begin
      wreg(ra[i], rw[i]);
      rreg(ra[i], v);
      chk8("readback", re[i], v);
    end
    // Short motion burst mid-count must restart the light count from zero
    for (int i = 0; i < 2; i++) begin
      wreg(sst_pkg::ENTRY_ADDR, {lc[i], 4'h0});
      motion <= 1'b0;
      repeat (100) @(posedge clk);
      motion <= 1'b1;
      @(posedge clk);
      motion <= 1'b0;
      wait_for(0, n);
      chk_rng("light delay", (int'(lc[i]) + 1) * 128 * CPM - 3, (int'(lc[i]) + 1) * 128 * CPM + 3, n);
      chk8("light flag", 8'h00, {7'h00, sleep_flag_q});
      @(posedge clk);
      motion <= 1'b1;
      wait_for(3, n);
      chk_rng("wake light", 1, 3, n);
    end
    wreg(sst_pkg::POLL_ADDR, 8'h02);
    motion <= 1'b0;
    wait_for(0, n);
    wait_for(1, n);
    chk_rng("deep delay", 20480 * CPM - 3, 20480 * CPM + 3, n);
    rreg(sst_pkg::STATUS_ADDR, v);
    chk8("deep status", 8'h0c, v);
    wait_for(2, n);
    wait_for(2, n);
    chk_rng("poll period", 32 * CPM, 32 * CPM, n);
    @(posedge clk);
    motion <= 1'b1;
    wait_for(3, n);
    chk_rng("wake deep", 1, 3, n);
    chk8("awake flag", 8'h00, {7'h00, sleep_flag_q});
    tally_and_finish();
  end

  // Whole run is about 50k cycles, mostly the deep delay; this leaves some slack
  initial begin
    #(40 * 65000);
    error_cnt++;
    $display("mismatch watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire
